// *** src/bsf_exec_regs.vh ***
// Constants for the bit-set-file execution unit.
// Function
// - An instruction word whose top four bits are 1000 sets the chosen bit of the byte and keeps the others.
// - With the bank flag at zero and no indexed addressing, the byte is taken from the shared access bank, ignoring the bank-select register.
// - With the bank flag at one the address is the bank-select register joined to the eight-bit field.
// - With extended instructions on, bank flag zero and field at most 95, indexed literal offset addressing is used.
`ifndef BSF_EXEC_REGS_VH
`define BSF_EXEC_REGS_VH
`define BSF_OPCODE        4'h8
`define BSF_OPC_HI        15
`define BSF_OPC_LO        12
`define BSF_BIT_HI        11
`define BSF_BIT_LO        9
`define BSF_BANK_BIT      8
`define BSF_ADDR_HI       7
`define BSF_ADDR_LO       0
`define BSF_INDEX_LIMIT   8'h5F
`define BSF_ACCESS_SPLIT  8'h60
`define BSF_ACCESS_HIBANK 4'hF
`define BSF_ACCESS_LOBANK 4'h0
`endif

// *** src/bsf_exec.v ***
// Bit-set-file instruction execution over four internal phases.
`timescale 1ns/1ps
`include "bsf_exec_regs.vh"
module bsf_exec
(
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire        instrValid,
    input  wire [15:0] instrWord,
    input  wire [3:0]  bankSelect,
    input  wire        extendedEnable,
    input  wire [11:0] indexBase,
    input  wire [7:0]  memReadData,
    output reg         busy,
    output reg  [11:0] memAddr,
    output reg         memRead,
    output reg         memWrite,
    output reg  [7:0]  memWriteData,
    output reg         done,
    output reg         statusWrite
);
    localparam [3:0] PH_IDLE  = 4'h1;
    localparam [3:0] PH_READ  = 4'h2;
    localparam [3:0] PH_PROC  = 4'h4;
    localparam [3:0] PH_WRITE = 4'h8;

    reg [3:0]  phase_reg;
    reg [3:0]  phase_next;
    reg [2:0]  bitSel_reg;
    reg [2:0]  bitSel_next;
    reg [7:0]  data_reg;
    reg [7:0]  data_next;
    reg        busy_next;
    reg [11:0] memAddr_next;
    reg        memRead_next;
    reg        memWrite_next;
    reg [7:0]  memWriteData_next;
    reg        done_next;

    wire        isBsf;
    wire [2:0]  bitField;
    wire        bankFlag;
    wire [7:0]  addrField;
    wire [11:0] effAddr;
    wire        acceptNow;

    // True when the upper nibble of the word names the bit-set operation.
    function is_bit_set_op;
        input [15:0] word;
        begin
            is_bit_set_op = (word[`BSF_OPC_HI:`BSF_OPC_LO] == `BSF_OPCODE);
        end
    endfunction

    // One-hot mask of the bit to be forced high.
    function [7:0] bit_mask;
        input [2:0] sel;
        begin
            bit_mask = 8'h01 << sel;
        end
    endfunction

    // Shared access bank: low part of the field in bank 0, the rest in the top bank.
    function [11:0] access_address;
        input [7:0] field;
        begin
            if (field < `BSF_ACCESS_SPLIT)
                access_address = {`BSF_ACCESS_LOBANK, field};
            else
                access_address = {`BSF_ACCESS_HIBANK, field};
        end
    endfunction

    // Effective data address; the indexed sum wraps at twelve bits on purpose,
    // since the data space is only that wide.
    function [11:0] eff_address;
        input        flag;
        input [3:0]  bank;
        input        ext;
        input [11:0] base;
        input [7:0]  field;
        begin
            if (flag)
                eff_address = {bank, field};
            else if (ext && (field <= `BSF_INDEX_LIMIT))
                eff_address = base + {4'h0, field};
            else
                eff_address = access_address(field);
        end
    endfunction

    assign isBsf     = is_bit_set_op(instrWord);
    assign bitField  = instrWord[`BSF_BIT_HI:`BSF_BIT_LO];
    assign bankFlag  = instrWord[`BSF_BANK_BIT];
    assign addrField = instrWord[`BSF_ADDR_HI:`BSF_ADDR_LO];
    assign effAddr   = eff_address(bankFlag, bankSelect, extendedEnable, indexBase, addrField);

    // Words offered while a previous instruction is still running are ignored.
    assign acceptNow = instrValid && isBsf && (phase_reg == PH_IDLE);

    // Next-state logic; strobes default low so each lasts exactly one cycle.
    always @*
    begin
        phase_next        = phase_reg;
        bitSel_next       = bitSel_reg;
        data_next         = data_reg;
        busy_next         = busy;
        memAddr_next      = memAddr;
        memRead_next      = 1'b0;
        memWrite_next     = 1'b0;
        memWriteData_next = memWriteData;
        done_next         = 1'b0;
        case (phase_reg)
            PH_IDLE:
            begin
                if (acceptNow)
                begin
                    memAddr_next = effAddr;
                    bitSel_next  = bitField;
                    memRead_next = 1'b1;
                    busy_next    = 1'b1;
                    phase_next   = PH_READ;
                end
            end
            PH_READ:
            begin
                data_next  = memReadData;
                phase_next = PH_PROC;
            end
            PH_PROC:
            begin
                memWriteData_next = data_reg | bit_mask(bitSel_reg);
                memWrite_next     = 1'b1;
                phase_next        = PH_WRITE;
            end
            PH_WRITE:
            begin
                done_next  = 1'b1;
                busy_next  = 1'b0;
                phase_next = PH_IDLE;
            end
            default:
            begin
                // An illegal phase code falls back to idle rather than hanging.
                busy_next  = 1'b0;
                phase_next = PH_IDLE;
            end
        endcase
    end

    // State and output registers; every output comes straight from a flip-flop.
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase_reg    <= PH_IDLE;
            bitSel_reg   <= 3'h0;
            data_reg     <= 8'h00;
            busy         <= 1'b0;
            memAddr      <= 12'h000;
            memRead      <= 1'b0;
            memWrite     <= 1'b0;
            memWriteData <= 8'h00;
            done         <= 1'b0;
            statusWrite  <= 1'b0;
        end
        else
        begin
            phase_reg    <= phase_next;
            bitSel_reg   <= bitSel_next;
            data_reg     <= data_next;
            busy         <= busy_next;
            memAddr      <= memAddr_next;
            memRead      <= memRead_next;
            memWrite     <= memWrite_next;
            memWriteData <= memWriteData_next;
            done         <= done_next;
            // Status flags are never touched by this instruction.
            statusWrite  <= 1'b0;
        end
    end
endmodule // bsf_exec

// *** dv/bsf_mem_model.sv ***
// Data memory model answering the bit-set unit.
`timescale 1ns/1ps
module bsf_mem_model (input wire clk_sys, memRead, memWrite, input wire [11:0] memAddr,
    input wire [7:0] memWriteData, output wire [7:0] memReadData);
    reg [7:0] mem [0:4095];
    integer i;
    initial for (i = 0; i < 4096; i = i + 1) mem[i] = 8'h0A;
    // Outside a read the line is inverted, so a late sample cannot pass.
    assign memReadData = memRead ? mem[memAddr] : ~mem[memAddr];
    always @(posedge clk_sys) if (memWrite) mem[memAddr] <= memWriteData;
endmodule // bsf_mem_model

// *** dv/bsf_exec_props.sv ***
// Checker of the bit-set unit's addressing, result and phase timing.
`timescale 1ns/1ps
module bsf_exec_props (input wire clk_sys, reset_n, instrValid, extendedEnable, busy, memRead,
    input wire memWrite, done, statusWrite, input wire [15:0] instrWord,
    input wire [3:0] bankSelect, input wire [11:0] indexBase, memAddr,
    input wire [7:0] memReadData, memWriteData);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire acc = instrValid && !busy && instrWord[15:12] == 4'h8;
    wire [7:0] f = instrWord[7:0];
    wire idx = extendedEnable && f <= 8'h5F;
    set_bit_a:
    assert property (memWrite |-> $countones(memWriteData ^ $past(memReadData, 2)) <= 1 &&
        (memWriteData & $past(memReadData, 2)) == $past(memReadData, 2)) else $error("bad byte");
    access_addr_a:
    assert property (acc && !instrWord[8] && !idx |=> memAddr ==
        {($past(f) >= 8'h60) ? 4'hF : 4'h0, $past(f)}) else $error("bad access address");
    bank_addr_a:
    assert property (acc && instrWord[8] |=> memAddr == {$past(bankSelect), $past(f)})
        else $error("bad bank address");
    index_addr_a:
    assert property (acc && !instrWord[8] && idx |=> memAddr == $past(indexBase) + $past(f))
        else $error("bad indexed address");
    phase_seq_a:
    assert property (acc |=> busy && memRead ##2 memWrite ##1 done && !busy) else $error("bad phases");
    no_status_a: assert property (!statusWrite) else $error("status written");
endmodule // bsf_exec_props
bind bsf_exec bsf_exec_props bsf_exec_props_inst (.clk_sys, .reset_n, .instrValid, .extendedEnable,
    .busy, .memRead, .memWrite, .done, .statusWrite, .instrWord, .bankSelect, .indexBase, .memAddr,
    .memReadData, .memWriteData);

// *** dv/bsf_exec_test.sv ***
// Self-checking bench of the bit-set unit.
`timescale 1ns/1ps
module bsf_exec_test;
    reg clk_sys = 0, reset_n = 0, instrValid = 0, extendedEnable = 0;
    reg [15:0] instrWord = 16'h0000;
    reg [3:0] bankSelect = 4'h0;
    wire busy, memRead, memWrite, done, statusWrite;
    wire [11:0] memAddr;
    wire [7:0] memReadData, memWriteData;
    integer bad_count = 0, n_checks = 0;
    always #25 clk_sys = ~clk_sys;
    bsf_exec bsf_exec_inst (.clk_sys, .reset_n, .instrValid, .instrWord, .bankSelect,
        .extendedEnable, .indexBase(12'hFF0), .memReadData, .busy, .memAddr, .memRead, .memWrite,
        .memWriteData, .done, .statusWrite);
    bsf_mem_model bsf_mem_model_inst (.clk_sys, .memRead, .memWrite, .memAddr, .memWriteData,
        .memReadData);
    task chk(input [11:0] got, exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp)
            begin
                bad_count = bad_count + 1;
                $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task run(input [15:0] w, input [3:0] bs, input e, input [11:0] ea, input [7:0] ed);
        integer i;
        begin
            @(posedge clk_sys);
            instrValid <= 1'b1;
            instrWord <= w;
            bankSelect <= bs;
            extendedEnable <= e;
            @(posedge clk_sys);
            instrValid <= 1'b0;
            for (i = 0; i < 8 && memWrite !== 1'b1; i = i + 1) @(negedge clk_sys);
            chk(memAddr, ea);
            chk({4'h0, memWriteData}, {4'h0, ed});
            @(negedge clk_sys);
            chk({10'h000, done, busy}, 12'h002);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task t_bank; run(16'h8F34, 4'h3, 1'b1, 12'h334, 8'h8A); endtask
    task t_split; run(16'h8060, 4'h3, 1'b1, 12'hF60, 8'h0B); endtask
    task t_index; run(16'h825F, 4'h3, 1'b1, 12'h04F, 8'h0A); endtask
    task t_low; run(16'h8410, 4'h7, 1'b0, 12'h010, 8'h0E); endtask
    initial
    begin
        #100000;
        bad_count = bad_count + 1;
        end_sim;
    end
    initial
    begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_bank; t_split; t_index; t_low;
        end_sim;
    end
endmodule // bsf_exec_test
